// File: rtl/bms_pkg.sv
// bms_pkg: constants, state codes and helpers of the boot mode selector.
// assumes a 250 MHz system clock and 16-bit flash words.
package bms_pkg;

   // boot-select codes {upper, lower}
   localparam logic [1:0]  SEL_USER      = 2'h3;
   localparam logic [1:0]  SEL_STANDARD  = 2'h2;
   localparam logic [1:0]  SEL_SELECTIVE = 2'h1;
   localparam logic [1:0]  SEL_RESERVED  = 2'h0;
   localparam logic [1:0]  SEL_RESET_VAL = 2'h3;

   // flash locations used by the selective check
   localparam int          ADDR_W        = 24;
   localparam int          WORD_W        = 16;
   localparam logic [23:0] SIG_ADDR_A    = 24'h00FFF8;
   localparam logic [23:0] SIG_ADDR_B    = 24'h00FFFA;
   localparam logic [23:0] KEY_ADDR      = 24'h00FFFC;
   localparam logic [15:0] SIG_REF       = 16'hFFFF;

   // user key codes
   localparam logic [15:0] KEY_STANDARD  = 16'h5A5A;
   localparam logic [15:0] KEY_UART_ONLY = 16'h5A01;
   localparam logic [15:0] KEY_CAN_ONLY  = 16'h5A02;

   // least dominant time that makes a valid CAN start
   localparam int          CLK_PERIOD_NS = 4;
   localparam int          CAN_DOM_NS    = 32;
   localparam logic [3:0]  CAN_DOM_CYC   =
      4'((CAN_DOM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   typedef enum logic [11:0] {
      ST_IDLE   = 12'h001,
      ST_DECODE = 12'h002,
      ST_RD_A   = 12'h004,
      ST_RD_B   = 12'h008,
      ST_CHECK  = 12'h010,
      ST_RD_KEY = 12'h020,
      ST_KEY    = 12'h040,
      ST_SWRST  = 12'h080,
      ST_USER   = 12'h100,
      ST_SCAN   = 12'h200,
      ST_LOOP   = 12'h400,
      ST_RSVD   = 12'h800
   } bms_state_t;

   function automatic logic sig_ok(input logic [15:0] a,
                                   input logic [15:0] b);
      sig_ok = ((a ^ b) == SIG_REF);
   endfunction

endpackage

// File: rtl/bms_start_detect.sv
// bms_start_detect: first-start detection on the UART and CAN receive lines.
// assumes receive lines synchronous to clk; arm is held while scanning.
`timescale 1ns/100ps
`default_nettype none

module bms_start_detect
   import bms_pkg::*;
(
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic arm,
   input  wire logic uart_en,
   input  wire logic can_en,
   input  wire logic uart_receive_line,
   input  wire logic can_receive_line,
   output logic      uart_start,
   output logic      can_start
);

   logic       uart_prev_q;
   logic       uart_prev_d;
   logic       can_idle_q;
   logic       can_idle_d;
   logic [3:0] dom_cnt_q;
   logic [3:0] dom_cnt_d;
   logic       uart_hit_q;
   logic       uart_hit_d;
   logic       can_hit_q;
   logic       can_hit_d;
   logic       locked;

   always_comb
   begin
      uart_prev_d = uart_receive_line;
      can_idle_d  = can_idle_q;
      dom_cnt_d   = 4'h0;
      uart_hit_d  = uart_hit_q;
      can_hit_d   = can_hit_q;
      locked      = uart_hit_q | can_hit_q;
      if (!arm)
      begin
         can_idle_d = 1'b0;
         uart_hit_d = 1'b0;
         can_hit_d  = 1'b0;
      end
      else if (!locked)
      begin
         if (can_receive_line)
            can_idle_d = 1'b1;
         if (can_en && can_idle_q && !can_receive_line)
            dom_cnt_d = dom_cnt_q + 4'h1;
         // uart falling edge from idle high; wins a tie
         if (uart_en && uart_prev_q && !uart_receive_line)
            uart_hit_d = 1'b1;
         else if (dom_cnt_d == CAN_DOM_CYC)
            can_hit_d = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         uart_prev_q <= 1'b1;
         can_idle_q  <= 1'b0;
         dom_cnt_q   <= 4'h0;
         uart_hit_q  <= 1'b0;
         can_hit_q   <= 1'b0;
      end
      else
      begin
         uart_prev_q <= uart_prev_d;
         can_idle_q  <= can_idle_d;
         dom_cnt_q   <= dom_cnt_d;
         uart_hit_q  <= uart_hit_d;
         can_hit_q   <= can_hit_d;
      end
   end

   assign uart_start = uart_hit_q;
   assign can_start  = can_hit_q;

   property p_uart_first;
      @(posedge clk) disable iff (reset)
      arm && uart_en && !uart_start && !can_start && uart_prev_q
         && !uart_receive_line |=> uart_start && !can_start;
   endproperty
   a_uart_first: assert property (p_uart_first)
      else $error("uart start not taken");

   property p_can_first;
      @(posedge clk) disable iff (reset)
      (arm && can_en && !uart_en && can_idle_q && !can_receive_line
         && !can_start) [*8] |=> can_start;
   endproperty
   a_can_first: assert property (p_can_first)
      else $error("can dominant not taken");

   property p_lock;
      @(posedge clk) disable iff (reset)
      arm && (uart_start || can_start) ##1 arm
         |-> $stable({uart_start, can_start});
   endproperty
   a_lock: assert property (p_lock)
      else $error("channel choice changed");

endmodule // bms_start_detect

`default_nettype wire

// File: rtl/bms_boot_mode_selector.sv
// bms_boot_mode_selector: reset-time boot mode decode and loader choice.
// assumes pins synchronous to clk and a flash read port answering with ack.
`timescale 1ns/100ps
`default_nettype none

module bms_boot_mode_selector
   import bms_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        external_reset_input_n,
   input  wire logic        boot_select_upper_bit,
   input  wire logic        boot_select_lower_bit,
   input  wire logic        uart_receive_line,
   input  wire logic        can_receive_line,
   input  wire logic        flash_rd_ack,
   input  wire logic [15:0] flash_rd_data,
   output logic             flash_rd_req,
   output logic [23:0]      flash_rd_addr,
   output logic [1:0]       boot_mode,
   output logic             user_flash_at_zero,
   output logic             fetch_from_test_flash,
   output logic             reserved_mode,
   output logic             sw_reset_pulse,
   output logic             run_user_code,
   output logic             standard_loader_active,
   output logic             uart_loader_run,
   output logic             can_loader_run,
   output logic             endless_loop
);

   // capture group
   logic       pin_q, pin_d;
   logic [1:0] sel_q, sel_d;
   logic       release_evt;
   always_comb
   begin
      pin_d       = external_reset_input_n;
      release_evt = external_reset_input_n && !pin_q;
      sel_d       = sel_q;
      if (release_evt)
         sel_d = {boot_select_upper_bit, boot_select_lower_bit};
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         pin_q <= 1'b0;
         sel_q <= SEL_RESET_VAL;
      end
      else
      begin
         pin_q <= pin_d;
         sel_q <= sel_d;
      end
   end

   // sequencing group
   bms_state_t  state_q, state_d;
   logic [15:0] word_a_q, word_a_d;
   logic [15:0] word_b_q, word_b_d;
   logic [15:0] key_q, key_d;
   logic        uart_en_q, uart_en_d;
   logic        can_en_q, can_en_d;
   logic        req_q, req_d;
   logic [23:0] addr_q, addr_d;
   logic        test_q, test_d;
   logic        zero_q, zero_d;
   logic        swrst_q, swrst_d;
   logic        run_q, run_d;
   logic        loop_q, loop_d;
   logic        rsvd_q, rsvd_d;
   always_comb
   begin
      state_d  = state_q;
      word_a_d = word_a_q;
      word_b_d = word_b_q;
      key_d    = key_q;
      uart_en_d = uart_en_q;
      can_en_d = can_en_q;
      req_d    = req_q;
      addr_d   = addr_q;
      test_d   = test_q;
      zero_d   = zero_q;
      swrst_d  = 1'b0;
      run_d    = run_q;
      loop_d   = loop_q;
      rsvd_d   = rsvd_q;
      if (!external_reset_input_n)
      begin
         state_d   = ST_IDLE;
         uart_en_d = 1'b0;
         can_en_d  = 1'b0;
         req_d     = 1'b0;
         test_d    = 1'b0;
         zero_d    = 1'b0;
         run_d     = 1'b0;
         loop_d    = 1'b0;
         rsvd_d    = 1'b0;
      end
      else
      begin
         unique case (state_q)
            ST_IDLE:
               if (release_evt)
                  state_d = ST_DECODE;
            ST_DECODE:
            begin
               // user flash is mapped at zero for data reads in every mode but reserved
               zero_d = 1'b1;
               unique case (sel_q)
                  SEL_USER:
                  begin
                     state_d = ST_USER;
                     run_d   = 1'b1;
                  end
                  SEL_STANDARD:
                  begin
                     state_d   = ST_SCAN;
                     test_d    = 1'b1;
                     uart_en_d = 1'b1;
                     can_en_d  = 1'b1;
                  end
                  SEL_SELECTIVE:
                  begin
                     state_d = ST_RD_A;
                     test_d  = 1'b1;
                     req_d   = 1'b1;
                     addr_d  = SIG_ADDR_A;
                  end
                  SEL_RESERVED:
                  begin
                     state_d = ST_RSVD;
                     zero_d  = 1'b0;
                     rsvd_d  = 1'b1;
                  end
               endcase
            end
            ST_RD_A:
               if (flash_rd_ack)
               begin
                  word_a_d = flash_rd_data;
                  addr_d   = SIG_ADDR_B;
                  state_d  = ST_RD_B;
               end
            ST_RD_B:
               if (flash_rd_ack)
               begin
                  word_b_d = flash_rd_data;
                  req_d    = 1'b0;
                  state_d  = ST_CHECK;
               end
            ST_CHECK:
               if (sig_ok(word_a_q, word_b_q))
                  state_d = ST_SWRST;
               else
               begin
                  state_d = ST_RD_KEY;
                  req_d   = 1'b1;
                  addr_d  = KEY_ADDR;
               end
            ST_RD_KEY:
               if (flash_rd_ack)
               begin
                  key_d   = flash_rd_data;
                  req_d   = 1'b0;
                  state_d = ST_KEY;
               end
            ST_KEY:
            begin
               state_d = ST_SCAN;
               if (key_q == KEY_STANDARD)
               begin
                  uart_en_d = 1'b1;
                  can_en_d  = 1'b1;
               end
               else if (key_q == KEY_UART_ONLY)
                  uart_en_d = 1'b1;
               else if (key_q == KEY_CAN_ONLY)
                  can_en_d = 1'b1;
               else
               begin
                  state_d = ST_LOOP;
                  loop_d  = 1'b1;
               end
            end
            ST_SWRST:
            begin
               swrst_d = 1'b1;
               test_d  = 1'b0;
               run_d   = 1'b1;
               state_d = ST_USER;
            end
            ST_USER, ST_SCAN, ST_LOOP, ST_RSVD: state_d = state_q;
         endcase
      end
   end
   always_ff @(posedge clk or posedge reset)
   begin
      if (reset)
      begin
         state_q   <= ST_IDLE;
         word_a_q  <= 16'h0000;
         word_b_q  <= 16'h0000;
         key_q     <= 16'h0000;
         uart_en_q <= 1'b0;
         can_en_q  <= 1'b0;
         req_q     <= 1'b0;
         addr_q    <= 24'h000000;
         test_q    <= 1'b0;
         zero_q    <= 1'b0;
         swrst_q   <= 1'b0;
         run_q     <= 1'b0;
         loop_q    <= 1'b0;
         rsvd_q    <= 1'b0;
      end
      else
      begin
         state_q   <= state_d;
         word_a_q  <= word_a_d;
         word_b_q  <= word_b_d;
         key_q     <= key_d;
         uart_en_q <= uart_en_d;
         can_en_q  <= can_en_d;
         req_q     <= req_d;
         addr_q    <= addr_d;
         test_q    <= test_d;
         zero_q    <= zero_d;
         swrst_q   <= swrst_d;
         run_q     <= run_d;
         loop_q    <= loop_d;
         rsvd_q    <= rsvd_d;
      end
   end
   logic scanning;
   assign scanning = (state_q == ST_SCAN) && external_reset_input_n;
   bms_start_detect bms_start_detect_inst (
      .clk               (clk),
      .reset             (reset),
      .arm               (scanning),
      .uart_en           (uart_en_q),
      .can_en            (can_en_q),
      .uart_receive_line (uart_receive_line),
      .can_receive_line  (can_receive_line),
      .uart_start        (uart_loader_run),
      .can_start         (can_loader_run)
   );
   assign flash_rd_req           = req_q;
   assign flash_rd_addr          = addr_q;
   assign boot_mode              = sel_q;
   assign user_flash_at_zero     = zero_q;
   assign fetch_from_test_flash  = test_q;
   assign reserved_mode          = rsvd_q;
   assign sw_reset_pulse         = swrst_q;
   assign run_user_code          = run_q;
   assign standard_loader_active = scanning;
   assign endless_loop           = loop_q;
   property p_capture;
      @(posedge clk) disable iff (reset)
      external_reset_input_n && !pin_q |=>
         boot_mode == $past({boot_select_upper_bit, boot_select_lower_bit});
   endproperty
   a_capture: assert property (p_capture)
      else $error("boot pins not latched at release");
   property p_user;
      @(posedge clk) disable iff (reset)
      state_q == ST_DECODE && sel_q == SEL_USER && external_reset_input_n
         |=> user_flash_at_zero && run_user_code && !fetch_from_test_flash;
   endproperty
   a_user: assert property (p_user)
      else $error("user mode map wrong");
   property p_standard;
      @(posedge clk) disable iff (reset)
      state_q == ST_DECODE && sel_q == SEL_STANDARD && external_reset_input_n
         |=> fetch_from_test_flash && user_flash_at_zero && uart_en_q
             && can_en_q && state_q == ST_SCAN;
   endproperty
   a_standard: assert property (p_standard)
      else $error("standard loader entry wrong");
   property p_selective;
      @(posedge clk) disable iff (reset)
      state_q == ST_DECODE && sel_q == SEL_SELECTIVE && external_reset_input_n
         |=> fetch_from_test_flash && flash_rd_req
             && flash_rd_addr == SIG_ADDR_A;
   endproperty
   a_selective: assert property (p_selective)
      else $error("selective entry wrong");
   property p_reserved;
      @(posedge clk) disable iff (reset)
      state_q == ST_DECODE && sel_q == SEL_RESERVED && external_reset_input_n
         |=> reserved_mode && !run_user_code && !standard_loader_active;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved code not flagged");
   property p_sig_good;
      @(posedge clk) disable iff (reset)
      state_q == ST_CHECK && sig_ok(word_a_q, word_b_q)
         && external_reset_input_n ##1 external_reset_input_n [*2]
         |-> sw_reset_pulse ##1 (run_user_code && !sw_reset_pulse);
   endproperty
   a_sig_good: assert property (p_sig_good)
      else $error("good signature did not start user code");
   property p_sig_bad;
      @(posedge clk) disable iff (reset)
      state_q == ST_CHECK && !sig_ok(word_a_q, word_b_q)
         && external_reset_input_n
         |=> flash_rd_req && flash_rd_addr == KEY_ADDR && !sw_reset_pulse;
   endproperty
   a_sig_bad: assert property (p_sig_bad)
      else $error("bad signature did not reread key");
   property p_key;
      @(posedge clk) disable iff (reset)
      state_q == ST_KEY && external_reset_input_n
         |=> (key_q == KEY_UART_ONLY) == (uart_en_q && !can_en_q)
             && (key_q == KEY_CAN_ONLY) == (can_en_q && !uart_en_q)
             && endless_loop == (!uart_en_q && !can_en_q);
   endproperty
   a_key: assert property (p_key)
      else $error("key decode wrong");

endmodule // bms_boot_mode_selector

`default_nettype wire

// File: sim/bms_host_model.sv
// bms_host_model: external host driving the uart and can receive lines.
// assumes its tasks are called by the bench, which waits on clk edges.
`timescale 1ns/100ps
`default_nettype none

module bms_host_model
(
   input  wire logic clk,
   output logic      uart_receive_line,
   output logic      can_receive_line
);
   // both lines rest at pull-up level
   initial
   begin
      uart_receive_line = 1'b1;
      can_receive_line  = 1'b1;
   end

   // start bit held four cycles, then back to idle high
   task automatic send_uart_start();
      @(posedge clk);
      uart_receive_line <= 1'b0;
      repeat (4) @(posedge clk);
      uart_receive_line <= 1'b1;
   endtask

   // dominant level for the given number of cycles
   task automatic send_can_dominant(input int cycles);
      @(posedge clk);
      can_receive_line <= 1'b0;
      repeat (cycles) @(posedge clk);
      can_receive_line <= 1'b1;
   endtask
endmodule // bms_host_model
`default_nettype wire

// File: sim/bms_boot_mode_selector_test.sv
// bms_boot_mode_selector_test: self-checking bench of the boot selector.
// assumes bms_pkg and the host model are compiled before this file.
`timescale 1ns/100ps
`default_nettype none

module bms_boot_mode_selector_test
   import bms_pkg::*;
;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        external_reset_input_n = 1'b0;
   logic        boot_select_upper_bit = 1'b1;
   logic        boot_select_lower_bit = 1'b1;
   logic        flash_rd_ack = 1'b0;
   logic [15:0] flash_rd_data = 16'h0000;
   logic        uart_receive_line;
   logic        can_receive_line;
   logic        flash_rd_req;
   logic [23:0] flash_rd_addr;
   logic [1:0]  boot_mode;
   logic        ufz, ftf, rsv, swp, run, sla, uar, canr, loopo;
   logic [2:0]  done_v;
   logic [15:0] fa = 16'h0000;
   logic [15:0] fb = 16'h0000;
   logic [15:0] fkey = 16'h0000;
   logic [23:0] addr_log [4];
   int          num_errors = 0;
   int          checks_done = 0;
   int          cycles = 0;
   int          lat = 0;
   int          cnt = 0;
   int          n_addr = 0;
   int          n_sw = 0;

   assign done_v = {loopo, sla, run};

   always #2 clk = ~clk;

   bms_boot_mode_selector bms_boot_mode_selector_inst (
      .clk                    (clk),
      .reset                  (reset),
      .external_reset_input_n (external_reset_input_n),
      .boot_select_upper_bit  (boot_select_upper_bit),
      .boot_select_lower_bit  (boot_select_lower_bit),
      .uart_receive_line      (uart_receive_line),
      .can_receive_line       (can_receive_line),
      .flash_rd_ack           (flash_rd_ack),
      .flash_rd_data          (flash_rd_data),
      .flash_rd_req           (flash_rd_req),
      .flash_rd_addr          (flash_rd_addr),
      .boot_mode              (boot_mode),
      .user_flash_at_zero     (ufz),
      .fetch_from_test_flash  (ftf),
      .reserved_mode          (rsv),
      .sw_reset_pulse         (swp),
      .run_user_code          (run),
      .standard_loader_active (sla),
      .uart_loader_run        (uar),
      .can_loader_run         (canr),
      .endless_loop           (loopo)
   );

   bms_host_model bms_host_model_inst (
      .clk               (clk),
      .uart_receive_line (uart_receive_line),
      .can_receive_line  (can_receive_line)
   );

   // flash answers after lat idle cycles; data scrambled when not acked
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      if (swp === 1'b1)
         n_sw <= n_sw + 1;
      if (flash_rd_req === 1'b1 && !flash_rd_ack && cnt >= lat)
      begin
         flash_rd_ack  <= 1'b1;
         flash_rd_data <= (flash_rd_addr == SIG_ADDR_A) ? fa :
                          (flash_rd_addr == SIG_ADDR_B) ? fb : fkey;
         if (n_addr < 4)
            addr_log[n_addr] <= flash_rd_addr;
         n_addr <= n_addr + 1;
         cnt <= 0;
      end
      else
      begin
         flash_rd_ack  <= 1'b0;
         flash_rd_data <= ~flash_rd_data;
         cnt <= (flash_rd_req === 1'b1 && !flash_rd_ack) ? cnt + 1 : 0;
      end
      if (cycles == 5000)
      begin
         num_errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [23:0] seen, input logic [23:0] exp,
                      input string what);
      checks_done++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: %s got %h want %h",
                  $time, what, seen, exp);
      end
   endtask

   // {ufz, ftf, rsv, run, sla, uar, canr, loop}
   function automatic logic [7:0] outs();
      return {ufz, ftf, rsv, run, sla, uar, canr, loopo};
   endfunction

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // pin low, set select bits, release; returns just after mode outputs
   task automatic do_boot(input logic [1:0] sel);
      @(posedge clk);
      external_reset_input_n <= 1'b0;
      repeat (3) @(posedge clk);
      n_addr <= 0;
      n_sw   <= 0;
      {boot_select_upper_bit, boot_select_lower_bit} <= sel;
      external_reset_input_n <= 1'b1;
      settle(3);
   endtask

   task automatic wait_for(input int which);
      for (int i = 0; i < 60; i++)
      begin
         settle(1);
         if (done_v[which] === 1'b1)
            return;
      end
      chk(24'h0, 24'h1, "wait timed out");
   endtask

   task automatic test_user();
      do_boot(SEL_USER);
      chk(boot_mode, SEL_USER, "user mode code");
      chk(outs(), 8'h90, "user outputs");
      @(posedge clk);
      {boot_select_upper_bit, boot_select_lower_bit} <= SEL_RESERVED;
      settle(3);
      chk(boot_mode, SEL_USER, "late pin change");
      chk(outs(), 8'h90, "user outputs held");
      $display("test user done");
   endtask

   task automatic test_reserved();
      do_boot(SEL_RESERVED);
      chk(boot_mode, SEL_RESERVED, "reserved code");
      settle(5);
      chk(outs(), 8'h20, "reserved outputs");
      $display("test reserved done");
   endtask

   task automatic test_std_uart();
      do_boot(SEL_STANDARD);
      chk(outs(), 8'hC8, "standard outputs");
      bms_host_model_inst.send_uart_start();
      settle(1);
      chk({uar, canr}, 2'h2, "uart win");
      bms_host_model_inst.send_can_dominant(10);
      settle(2);
      chk({uar, canr}, 2'h2, "can after uart");
      $display("test standard uart done");
   endtask

   task automatic test_std_can();
      do_boot(SEL_STANDARD);
      bms_host_model_inst.send_can_dominant(7);
      settle(2);
      chk({uar, canr}, 2'h0, "short dominant");
      bms_host_model_inst.send_can_dominant(8);
      settle(0);
      chk({uar, canr}, 2'h1, "can win");
      bms_host_model_inst.send_uart_start();
      settle(2);
      chk({uar, canr}, 2'h1, "uart after can");
      $display("test standard can done");
   endtask

   task automatic test_sel_good();
      fa  = 16'h1234;
      fb  = SIG_REF ^ 16'h1234;
      lat = 3;
      do_boot(SEL_SELECTIVE);
      chk(boot_mode, SEL_SELECTIVE, "selective code");
      chk(ftf, 1'b1, "selective fetch");
      wait_for(0);
      // pulse counter updates one edge after run rises
      settle(1);
      chk(addr_log[0], SIG_ADDR_A, "first word");
      chk(addr_log[1], SIG_ADDR_B, "second word");
      chk(24'(n_addr), 24'h2, "read count");
      chk(24'(n_sw), 24'h1, "software reset");
      chk(ftf, 1'b0, "fetch after reset");
      $display("test selective good done");
   endtask

   task automatic test_sel_keys();
      logic [15:0] keys [4];
      keys = '{KEY_STANDARD, KEY_UART_ONLY, KEY_CAN_ONLY, 16'h1234};
      fa  = 16'h0000;
      fb  = 16'h0000;
      lat = 0;
      for (int k = 0; k < 4; k++)
      begin
         fkey = keys[k];
         do_boot(SEL_SELECTIVE);
         wait_for(k == 3 ? 2 : 1);
         chk(addr_log[2], KEY_ADDR, "key read");
         chk(24'(n_addr), 24'h3, "key read count");
         chk(run, 1'b0, "no user run");
         if (k == 0 || k == 1)
         begin
            bms_host_model_inst.send_can_dominant(8);
            settle(0);
            chk({uar, canr}, k == 0 ? 2'h1 : 2'h0, "can by key");
         end
         if (k == 1 || k == 2)
         begin
            bms_host_model_inst.send_uart_start();
            settle(1);
            chk({uar, canr}, k == 1 ? 2'h2 : 2'h0, "uart by key");
         end
         if (k == 2)
         begin
            bms_host_model_inst.send_can_dominant(8);
            settle(0);
            chk({uar, canr}, 2'h1, "can only key");
         end
         if (k == 3)
            chk({sla, loopo}, 2'h1, "bad key loop");
      end
      $display("test selective keys done");
   endtask

   initial
   begin
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      test_user();
      test_reserved();
      test_std_uart();
      test_std_can();
      test_sel_good();
      test_sel_keys();
      finish_test();
   end
endmodule // bms_boot_mode_selector_test
`default_nettype wire
